// ===== src/inp_ctrl.sv
// interrupt acknowledge, nesting and pending control with register slave
//
// How it works
// - enable and in-service flags live inside the status word register
// - in-service flag 0 means high level served, 1 means idle or low
// - enable flag 0 blocks maskable acknowledge, 1 allows it
// - per-source priority bits in three byte registers, 0 high, 1 low
// - nesting a maskable request needs the enable flag set again by EI
// - lower priority request waits pending until after return plus one instr
// - with enable clear, new maskable requests wait until after return
// - status word and EI/DI/return instructions defer acknowledge one instr
// - writes to request, mask, priority or edge registers also defer
// - break itself does not defer but clears enable, blocking maskables
// - non-maskable request is taken even after break cleared enable
// - request flags set regardless of the source priority bit
// - acknowledge saves status word, clears enable; maskable one also copies priority bit
// - only break nests while a non-maskable service is running
// - high service nests only high requests, low service any, soft service per the in-service flag it entered with
// - high priority pending first, ties by lowest source index
`timescale 1ns/1ps
`default_nettype none
module inp_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus write side
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // register bus read side
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // instruction sequencer
    input wire logic instr_done,
    input wire logic instr_defer,
    input wire logic ei_exec,
    input wire logic di_exec,
    input wire logic brk_exec,
    input wire logic ret_exec,
    input wire logic psw_load,
    input wire logic [7:0] psw_load_data,
    // request sources
    input wire logic [23:0] src_req,
    input wire logic nmi_req,
    // acknowledge towards sequencer
    output logic ack_valid,
    output logic ack_nmi,
    output logic ack_soft,
    output logic [4:0] ack_source,
    output logic [7:0] saved_psw,
    output logic [7:0] program_status_word,
    // edge selection towards external pin detectors
    output logic [7:0] rising_edge_select_reg,
    output logic [7:0] falling_edge_select_reg,
    output logic [7:0] rising_edge_select_reg_b,
    output logic [7:0] falling_edge_select_reg_b
);

    // lowest set bit index and presence flag
    function automatic logic [5:0] first_set(input logic [23:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = inp_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [23:0] req_flags;
    logic [23:0] mask_bits;
    logic [23:0] prio_bits;
    logic nmi_pend;
    logic reg_touch;
    logic [inp_pkg::STK_DEPTH-1:0] nmi_stack;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_en_q;

    ////////////////////////////////////////////////////////////////////////
    // acknowledge decision
    wire logic ie = program_status_word[inp_pkg::PSW_IE_BIT];
    wire logic in_service_priority_flag = program_status_word[inp_pkg::PSW_ISP_BIT];
    wire logic in_nmi = nmi_stack[0];
    wire logic [23:0] pend = req_flags & ~mask_bits;
    wire logic [23:0] pend_hi = pend & ~prio_bits;
    wire logic [5:0] pick_hi = first_set(pend_hi);
    wire logic [5:0] pick_any = first_set(pend);
    wire logic [5:0] pick = pick_hi[5] ? pick_hi : pick_any;
    wire logic pick_prio = prio_bits[pick[4:0]];
    // boundary at which a request acknowledge may happen; break bypasses it
    wire logic slot = instr_done & ~instr_defer & ~reg_touch
        & ~brk_exec & ~in_nmi;
    wire logic take_nmi = slot & nmi_pend;
    wire logic take_mask = slot & ~nmi_pend & pick[5] & ie
        & (in_service_priority_flag | ~pick_prio);
    wire logic take_brk = instr_done & brk_exec;
    wire logic take_any = take_nmi | take_mask | take_brk;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic wr_go = aw_held & w_held & ~bvalid;
    wire logic [7:0] wa = aw_addr_q;
    wire logic wr_req0l = wr_go & w_en_q & (wa == inp_pkg::OFS_REQ0L);
    wire logic wr_req0h = wr_go & w_en_q & (wa == inp_pkg::OFS_REQ0H);
    wire logic wr_req1l = wr_go & w_en_q & (wa == inp_pkg::OFS_REQ1L);
    wire logic wr_irq_reg = wr_go & (wa >= inp_pkg::OFS_REQ0L)
        & (wa <= inp_pkg::OFS_EGF_B) & (wa[1:0] == 2'b00);
    wire logic wr_ok = wr_go & ((wa[1:0] == 2'b00) & (wa <= inp_pkg::OFS_STAT));
    wire logic [7:0] wd = w_data_q;
    wire logic rd_go = arvalid & arready;
    wire logic rd_ok = (araddr[1:0] == 2'b00) & (araddr <= inp_pkg::OFS_STAT);
    logic [7:0] rd_mux;
    wire logic [7:0] stat_word = {4'h0, nmi_pend, in_nmi, in_service_priority_flag, ie};

    // read data selection
    always_comb
    begin
        case (araddr)
            inp_pkg::OFS_PSW: rd_mux = program_status_word;
            inp_pkg::OFS_REQ0L: rd_mux = req_flags[7:0];
            inp_pkg::OFS_REQ0H: rd_mux = req_flags[15:8];
            inp_pkg::OFS_REQ1L: rd_mux = req_flags[23:16];
            inp_pkg::OFS_MSK0L: rd_mux = mask_bits[7:0];
            inp_pkg::OFS_MSK0H: rd_mux = mask_bits[15:8];
            inp_pkg::OFS_MSK1L: rd_mux = mask_bits[23:16];
            inp_pkg::OFS_PRI0L: rd_mux = prio_bits[7:0];
            inp_pkg::OFS_PRI0H: rd_mux = prio_bits[15:8];
            inp_pkg::OFS_PRI1L: rd_mux = prio_bits[23:16];
            inp_pkg::OFS_EGR: rd_mux = rising_edge_select_reg;
            inp_pkg::OFS_EGF: rd_mux = falling_edge_select_reg;
            inp_pkg::OFS_EGR_B: rd_mux = rising_edge_select_reg_b;
            inp_pkg::OFS_EGF_B: rd_mux = falling_edge_select_reg_b;
            inp_pkg::OFS_STAT: rd_mux = stat_word;
            default: rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // request flags: hardware set wins over software clear
    logic [23:0] sw_val;
    logic [23:0] sw_wen;
    logic [23:0] ack_clr;
    always_comb
    begin
        sw_val = {wd, wd, wd};
        sw_wen = {{8{wr_req1l}}, {8{wr_req0h}}, {8{wr_req0l}}};
        ack_clr = 24'h000000;
        if (take_mask)
        begin
            ack_clr[pick[4:0]] = 1'b1;
        end
    end
    wire logic [23:0] next_req = (((req_flags & ~sw_wen) | (sw_val & sw_wen))
        & ~ack_clr) | src_req;

    // request, nmi pending and touch flag
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            req_flags <= {3{inp_pkg::REQ_RESET}};
            nmi_pend <= 1'b0;
            reg_touch <= 1'b0;
        end
        else
        begin
            req_flags <= next_req;
            nmi_pend <= nmi_req | (nmi_pend & ~take_nmi);
            reg_touch <= wr_irq_reg | (reg_touch & ~instr_done);
        end
    end

    // mask, priority and edge selection registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask_bits <= {3{inp_pkg::MSK_RESET}};
            prio_bits <= {3{inp_pkg::PRI_RESET}};
            rising_edge_select_reg <= inp_pkg::EDGE_RESET;
            falling_edge_select_reg <= inp_pkg::EDGE_RESET;
            rising_edge_select_reg_b <= inp_pkg::EDGE_RESET;
            falling_edge_select_reg_b <= inp_pkg::EDGE_RESET;
        end
        else if (wr_go && w_en_q)
        begin
            case (wa)
                inp_pkg::OFS_MSK0L: mask_bits[7:0] <= wd;
                inp_pkg::OFS_MSK0H: mask_bits[15:8] <= wd;
                inp_pkg::OFS_MSK1L: mask_bits[23:16] <= wd;
                inp_pkg::OFS_PRI0L: prio_bits[7:0] <= wd;
                inp_pkg::OFS_PRI0H: prio_bits[15:8] <= wd;
                inp_pkg::OFS_PRI1L: prio_bits[23:16] <= wd;
                inp_pkg::OFS_EGR: rising_edge_select_reg <= wd;
                inp_pkg::OFS_EGF: falling_edge_select_reg <= wd;
                inp_pkg::OFS_EGR_B: rising_edge_select_reg_b <= wd;
                inp_pkg::OFS_EGF_B: falling_edge_select_reg_b <= wd;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word next value
    logic [7:0] next_psw;
    always_comb
    begin
        next_psw = program_status_word;
        if (take_any)
        begin
            next_psw[inp_pkg::PSW_IE_BIT] = 1'b0;
            if (take_mask)
            begin
                next_psw[inp_pkg::PSW_ISP_BIT] = pick_prio;
            end
        end
        else if (psw_load)
        begin
            next_psw = psw_load_data;
        end
        else if (ei_exec)
        begin
            next_psw[inp_pkg::PSW_IE_BIT] = 1'b1;
        end
        else if (di_exec)
        begin
            next_psw[inp_pkg::PSW_IE_BIT] = 1'b0;
        end
    end

    // status word and service kind stack
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            program_status_word <= inp_pkg::PSW_RESET;
            nmi_stack <= '0;
        end
        else
        begin
            program_status_word <= next_psw;
            if (take_any)
            begin
                nmi_stack <= {nmi_stack[inp_pkg::STK_DEPTH-2:0], take_nmi};
            end
            else if (ret_exec)
            begin
                nmi_stack <= {1'b0, nmi_stack[inp_pkg::STK_DEPTH-1:1]};
            end
        end
    end

    // acknowledge outputs towards the sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ack_valid <= 1'b0;
            ack_nmi <= 1'b0;
            ack_soft <= 1'b0;
            ack_source <= 5'h00;
            saved_psw <= 8'h00;
        end
        else
        begin
            ack_valid <= take_any;
            ack_nmi <= take_nmi;
            ack_soft <= take_brk;
            if (take_mask)
            begin
                ack_source <= pick[4:0];
            end
            if (take_any)
            begin
                saved_psw <= program_status_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus write channel: address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_en_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= inp_pkg::RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data_q <= wdata[7:0];
                w_en_q <= wstrb[0];
            end
            if (wr_go)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? inp_pkg::RESP_OKAY : inp_pkg::RESP_SLVERR;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    // ready flags for write address and data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            wready <= 1'b0;
        end
        else
        begin
            awready <= ~aw_held & ~(awvalid & awready) & ~bvalid;
            wready <= ~w_held & ~(wvalid & wready) & ~bvalid;
        end
    end

    // bus read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= inp_pkg::RESP_OKAY;
        end
        else
        begin
            arready <= ~rvalid & ~rd_go;
            if (rd_go)
            begin
                rvalid <= 1'b1;
                rdata <= {24'h000000, rd_mux};
                rresp <= rd_ok ? inp_pkg::RESP_OKAY : inp_pkg::RESP_SLVERR;
            end
            else if (rvalid && rready)
            begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ===== src/inp_pkg.sv
// constants for the interrupt nesting and pending control block
package inp_pkg;
    localparam int NSRC = 24;
    localparam int SIDX_W = 5;
    localparam int STK_DEPTH = 4;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_PSW = 8'h00;
    localparam logic [7:0] OFS_REQ0L = 8'h04;
    localparam logic [7:0] OFS_REQ0H = 8'h08;
    localparam logic [7:0] OFS_REQ1L = 8'h0C;
    localparam logic [7:0] OFS_MSK0L = 8'h10;
    localparam logic [7:0] OFS_MSK0H = 8'h14;
    localparam logic [7:0] OFS_MSK1L = 8'h18;
    localparam logic [7:0] OFS_PRI0L = 8'h1C;
    localparam logic [7:0] OFS_PRI0H = 8'h20;
    localparam logic [7:0] OFS_PRI1L = 8'h24;
    localparam logic [7:0] OFS_EGR = 8'h28;
    localparam logic [7:0] OFS_EGF = 8'h2C;
    localparam logic [7:0] OFS_EGR_B = 8'h30;
    localparam logic [7:0] OFS_EGF_B = 8'h34;
    localparam logic [7:0] OFS_STAT = 8'h38;
    // status word field positions and reset values
    localparam int PSW_IE_BIT = 7;
    localparam int PSW_ISP_BIT = 1;
    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam logic [7:0] MSK_RESET = 8'hFF;
    localparam logic [7:0] PRI_RESET = 8'hFF;
    localparam logic [7:0] REQ_RESET = 8'h00;
    localparam logic [7:0] EDGE_RESET = 8'h00;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== tb/inp_ctrl_chk.sv
// concurrent checks on the acknowledge decision of the nesting control
`timescale 1ns/1ps
`default_nettype none
module inp_ctrl_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    // sequencer
    input wire logic instr_done,
    input wire logic instr_defer,
    input wire logic brk_exec,
    input wire logic psw_load,
    input wire logic [7:0] psw_load_data,
    // acknowledge
    input wire logic ack_valid,
    input wire logic ack_nmi,
    input wire logic ack_soft,
    input wire logic [7:0] saved_psw,
    input wire logic [7:0] program_status_word
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // maskable acknowledge, flag views and control-register write
    wire mack = ack_valid && !ack_nmi && !ack_soft;
    wire ie_now = program_status_word[inp_pkg::PSW_IE_BIT];
    wire isp_now = program_status_word[inp_pkg::PSW_ISP_BIT];
    wire ctl_wr = awvalid && awready && awaddr[1:0] == 2'b00
        && awaddr >= inp_pkg::OFS_REQ0L && awaddr <= inp_pkg::OFS_EGF_B;
    logic wr_seen;
    // control-register write seen since the last boundary
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wr_seen <= 1'b0;
        else if (ctl_wr)
            wr_seen <= 1'b1;
        else if (instr_done)
            wr_seen <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    a_ack_on_boundary: assert property (ack_valid |-> $past(instr_done))
        else $error("acknowledge without instruction boundary");
    a_defer_holds: assert property (instr_done && instr_defer |=> !ack_valid)
        else $error("acknowledge after deferring instruction");
    a_write_defers: assert property (instr_done && wr_seen |=> !ack_valid)
        else $error("acknowledge after control register write");
    a_break_soft: assert property (instr_done && brk_exec && !instr_defer
        && !wr_seen |=> ack_valid && ack_soft)
        else $error("break not acknowledged as software");
    a_ack_clears_ie: assert property (ack_valid |-> !ie_now)
        else $error("enable flag left set after acknowledge");
    a_mask_needs_ie: assert property (mack
        |-> saved_psw[inp_pkg::PSW_IE_BIT])
        else $error("maskable acknowledge with enable clear");
    a_high_stays_high: assert property (mack
        && !saved_psw[inp_pkg::PSW_ISP_BIT] |-> !isp_now)
        else $error("low request nested in high service");
    a_psw_restore: assert property (psw_load && !instr_done
        |=> program_status_word == $past(psw_load_data))
        else $error("status word not loaded");
endmodule
bind inp_ctrl inp_ctrl_chk u_inp_ctrl_chk (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .instr_done,
    .instr_defer, .brk_exec, .psw_load, .psw_load_data, .ack_valid,
    .ack_nmi, .ack_soft, .saved_psw, .program_status_word
);
`default_nettype wire

// ===== tb/inp_ctrl_tb.sv
// self-checking bench for the interrupt nesting control block
`timescale 1ns/1ps
`default_nettype none
module inp_ctrl_tb;
    localparam logic [2:0] NO = 3'b000, MK = 3'b100;
    localparam logic [2:0] SW = 3'b101, NM = 3'b110;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, fire = 1'b0;
    logic fire_nmi = 1'b0, instr_done = 1'b0, instr_defer = 1'b0;
    logic ei_exec = 1'b0, di_exec = 1'b0, brk_exec = 1'b0;
    logic ret_exec = 1'b0, psw_load = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, psw_load_data = 8'h00, p;
    logic [31:0] wdata = 32'h0, seed = 32'h3B0F1747, r, rdata;
    logic [3:0] wstrb = 4'hF;
    logic [23:0] fire_vec = 24'h0, src_req;
    logic awready, wready, bvalid, arready, rvalid, nmi_req;
    logic ack_valid, ack_nmi, ack_soft;
    logic [1:0] bresp, rresp;
    logic [4:0] ack_source;
    logic [7:0] saved_psw, program_status_word, rising_edge_select_reg;
    logic [7:0] falling_edge_select_reg, rising_edge_select_reg_b;
    logic [7:0] falling_edge_select_reg_b;
    int n_mismatch = 0, comparisons = 0, cyc = 0, s, t, h, e;
    ////////////////////////////////////////////////////////////////////////
    // design and request sources
    inp_ctrl u_inp_ctrl (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .instr_done,
        .instr_defer, .ei_exec, .di_exec, .brk_exec, .ret_exec,
        .psw_load, .psw_load_data, .src_req, .nmi_req, .ack_valid,
        .ack_nmi, .ack_soft, .ack_source, .saved_psw,
        .program_status_word, .rising_edge_select_reg,
        .falling_edge_select_reg, .rising_edge_select_reg_b,
        .falling_edge_select_reg_b
    );
    inp_src_model u_inp_src_model (
        .aclk, .aresetn, .fire, .fire_vec, .fire_nmi, .src_req, .nmi_req
    );
    // 125 MHz clock
    always #4 aclk = ~aclk;
    // hang guard
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // xorshift source and expected winner among pending requests
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int exp_src(input logic [7:0] q, input logic [7:0] pr);
        for (int i = 0; i < 8; i++)
            if (q[i] && !pr[i])
                return i;
        for (int i = 0; i < 8; i++)
            if (q[i])
                return i;
        return 31;
    endfunction
    // compare, count and report
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    // bus write and read, each held until taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(inp_pkg::RESP_OKAY), 32'(bresp));
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [1:0] xr);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        chk("rdata", {24'h0, x}, rdata);
        chk("rresp", {30'h0, xr}, {30'h0, rresp});
        @(posedge aclk);
    endtask
    // request pulses from the source model
    task automatic fire_src(input logic [23:0] v, input logic n);
        fire <= 1'b1;
        fire_vec <= v;
        fire_nmi <= n;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    // enable, return and status word load pulses
    task automatic seq(input logic ei, input logic rt, input logic [7:0] v);
        ei_exec <= ei;
        ret_exec <= rt;
        psw_load <= !ei;
        psw_load_data <= v;
        @(posedge aclk);
        ei_exec <= 1'b0;
        ret_exec <= 1'b0;
        psw_load <= 1'b0;
        @(posedge aclk);
    endtask
    // one instruction boundary and the acknowledge it yields
    task automatic ins(input logic d, input logic b, input logic [2:0] k, input int src);
        instr_done <= 1'b1;
        instr_defer <= d;
        brk_exec <= b;
        @(posedge aclk);
        instr_done <= 1'b0;
        instr_defer <= 1'b0;
        brk_exec <= 1'b0;
        @(posedge aclk);
        chk("ack_kind", {29'h0, k}, {29'h0, ack_valid, ack_nmi, ack_soft});
        if (k == MK)
            chk("ack_source", {27'h0, src[4:0]}, {27'h0, ack_source});
    endtask
    task automatic ret(input logic [7:0] v);
        seq(1'b0, 1'b1, v);
        ins(1'b1, 1'b0, NO, 0);
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 8'h02, 2'b00);
        rd(8'h10, 8'hFF, 2'b00);
        rd(8'h1C, 8'hFF, 2'b00);
        rd(8'h3C, 8'h00, inp_pkg::RESP_SLVERR);
        r = rnd();
        wr(8'h28, r[7:0]);
        rd(8'h28, r[7:0], 2'b00);
        chk("edge_out", {24'h0, r[7:0]}, {24'h0, rising_edge_select_reg});
        r = rnd();
        wr(8'h2C, r[7:0]);
        wr(8'h30, r[15:8]);
        wr(8'h34, r[23:16]);
        chk("efall", 32'(r[7:0]), 32'(falling_edge_select_reg));
        chk("erise_b", 32'(r[15:8]), 32'(rising_edge_select_reg_b));
        chk("efall_b", 32'(r[23:16]), 32'(falling_edge_select_reg_b));
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h02, 2'b00);
        fire_src(24'h100000, 1'b0);
        rd(8'h0C, 8'h10, 2'b00);
        wr(8'h0C, 8'h00);
        s = int'(rnd() % 32'd8);
        t = (s + 1) % 8;
        h = (s + 2) % 8;
        seq(1'b0, 1'b0, 8'h82);
        wr(8'h10, ~(8'h01 << s));
        fire_src(24'h1 << s, 1'b0);
        ins(1'b0, 1'b0, NO, 0);
        ins(1'b0, 1'b0, MK, s);
        chk("psw", 32'h02, {24'h0, program_status_word});
        chk("saved_psw", 32'h82, {24'h0, saved_psw});
        wr(8'h10, 8'h00);
        fire_src(24'h1 << t, 1'b0);
        ins(1'b0, 1'b0, NO, 0);
        ins(1'b0, 1'b0, NO, 0);
        ret(8'h82);
        ins(1'b0, 1'b0, MK, t);
        wr(8'h1C, ~(8'h01 << h));
        fire_src(24'h1 << h, 1'b0);
        seq(1'b1, 1'b0, 8'h00);
        ins(1'b1, 1'b0, NO, 0);
        ins(1'b0, 1'b0, MK, h);
        chk("psw", 32'h00, {24'h0, program_status_word});
        seq(1'b1, 1'b0, 8'h00);
        fire_src(24'h1 << t, 1'b0);
        ins(1'b1, 1'b0, NO, 0);
        ins(1'b0, 1'b0, NO, 0);
        fire_src(24'h1 << h, 1'b0);
        ins(1'b0, 1'b0, MK, h);
        ret(8'h82);
        ins(1'b0, 1'b0, MK, t);
        repeat (3) ret(8'h82);
        r = rnd();
        p = r[7:0] | (8'h01 << h);
        fire_src({16'h0, p}, 1'b0);
        while (p != 8'h00)
        begin
            e = exp_src(p, ~(8'h01 << h));
            ins(1'b0, 1'b0, MK, e);
            p[e] = 1'b0;
            ret(8'h82);
        end
        fire_src(24'h000002, 1'b1);
        ins(1'b0, 1'b1, SW, 0);
        ins(1'b0, 1'b0, NM, 0);
        seq(1'b1, 1'b0, 8'h00);
        ins(1'b1, 1'b0, NO, 0);
        ins(1'b0, 1'b0, NO, 0);
        ret(8'h82);
        ins(1'b0, 1'b0, MK, 1);
        repeat (2) ret(8'h82);
        di_exec <= 1'b1;
        @(posedge aclk);
        di_exec <= 1'b0;
        @(posedge aclk);
        chk("psw_di", 32'h02, 32'(program_status_word));
        fire_src(24'h000001, 1'b0);
        ins(1'b0, 1'b0, NO, 0);
        test_done();
    end
endmodule
`default_nettype wire

// ===== tb/inp_src_model.sv
// request source model raising one-cycle request pulses
`timescale 1ns/1ps
`default_nettype none
module inp_src_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // commands from the bench
    input wire logic fire,
    input wire logic [23:0] fire_vec,
    input wire logic fire_nmi,
    // request pulses
    output logic [23:0] src_req,
    output logic nmi_req
);
    // pulses whatever the priority bits say, low otherwise
    always_ff @(posedge aclk)
    begin
        src_req <= (aresetn && fire) ? fire_vec : 24'h000000;
        nmi_req <= aresetn && fire && fire_nmi;
    end
endmodule
`default_nettype wire
